// >>> prmpio_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Bus cycle and port timing checker
module prmpio_asserts (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Processor bus
  input wire prmpio_pkg::prmpio_req_t bus_req_i,
  input wire logic bus_busy_o,
  input wire logic bus_ack_o,
  input wire logic [prmpio_pkg::DATA_W-1:0] bus_rdata_o,
  // Pins and peripherals
  input wire prmpio_pkg::prmpio_pins_t pin_out_o,
  input wire prmpio_pkg::prmpio_pins_t pin_oe_o,
  input wire prmpio_pkg::prmpio_wev_t periph_wr_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  // Request accepted while idle
  logic take;
  assign take = !bus_busy_o && (bus_req_i.rd || bus_req_i.wr);
  a_ack_three_late: assert property (take |-> ##3 bus_ack_o)
    else $error("ack not three cycles after take");
  a_busy_span: assert property (take |=> bus_busy_o [*3] ##1 !bus_busy_o)
    else $error("busy span wrong");
  a_ack_one_cycle: assert property (bus_ack_o |=> !bus_ack_o)
    else $error("ack longer than one cycle");
  a_busy_until_ack: assert property (bus_busy_o && !bus_ack_o |=> bus_busy_o)
    else $error("busy dropped before ack");
  // Latch moves only at the end of a store
  a_latch_on_store: assert property ($changed(pin_out_o) |-> bus_ack_o && $past(bus_req_i.wr, 3))
    else $error("pin latch changed outside a store");
  // Read data moves only at the first substate sample
  a_rdata_first_sub: assert property ($changed(bus_rdata_o)
    |-> bus_busy_o && $past(bus_busy_o) && !$past(bus_busy_o, 2) && $past(bus_req_i.rd, 2))
    else $error("read data changed outside first substate");
  a_wr_event_match: assert property (periph_wr_o.valid |-> bus_ack_o && $past(bus_req_i.wr, 3)
    && periph_wr_o.addr == $past(bus_req_i.addr, 3) && periph_wr_o.data == $past(bus_req_i.wdata, 3))
    else $error("peripheral write does not match store");
  a_wr_in_region: assert property (periph_wr_o.valid
    |-> periph_wr_o.addr <= 12'h03F || periph_wr_o.addr >= 12'hF80)
    else $error("peripheral write outside mapped regions");
  a_narrow_ports: assert property ((pin_oe_o[2] & 8'hF8) == 8'h00 && (pin_oe_o[4] & 8'hF0) == 8'h00)
    else $error("missing port bit driven");
endmodule

bind prmpio_top prmpio_asserts u_asserts (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .bus_req_i(bus_req_i),
  .bus_busy_o(bus_busy_o), .bus_ack_o(bus_ack_o), .bus_rdata_o(bus_rdata_o), .pin_out_o(pin_out_o),
  .pin_oe_o(pin_oe_o), .periph_wr_o(periph_wr_o));
`default_nettype wire

// >>> prmpio_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Processor core issuing single byte loads and stores
module prmpio_core_model (
  // Clock
  input wire logic mclk_i,
  // Bus answer
  input wire logic bus_ack_o,
  input wire logic [prmpio_pkg::DATA_W-1:0] bus_rdata_o,
  // Bus request
  output var prmpio_pkg::prmpio_req_t bus_req_o
);
  // Transfers that never saw ack
  int hang_cnt = 0;
  initial bus_req_o = '0;
  // Whole byte access, held until ack is sampled
  task automatic xfer(input logic is_rd, input logic [11:0] a, input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge mclk_i);
    bus_req_o <= '{rd: is_rd, wr: !is_rd, addr: a, wdata: d};
    @(posedge mclk_i);
    while (bus_ack_o !== 1'b1 && n < 16)
    begin
      @(posedge mclk_i);
      n++;
    end
    q = bus_rdata_o;
    if (n == 16)
      hang_cnt++;
    // Released lines flip so stale values are not seen
    bus_req_o <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
  endtask
endmodule
`default_nettype wire

// >>> prmpio_pkg.sv
package prmpio_pkg;

  // ==========================================================
  // Widths and counts
  localparam int NPORT = 8;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int EXT_N = 9;
  localparam int STORE_N = 192;

  // Per-port implemented bit masks, index = port number
  localparam logic [NPORT-1:0][DATA_W-1:0] PORT_MASK = {8'hFF, 8'hFF, 8'hFF, 8'h0F, 8'hFF, 8'h07, 8'hFF, 8'hFF};

  // ==========================================================
  // Address regions
  localparam logic [ADDR_W-1:0] SPEC_FIRST = 12'h000;
  localparam logic [ADDR_W-1:0] SPEC_LAST = 12'h03F;
  localparam logic [ADDR_W-1:0] DBUF_FIRST = 12'hF80;
  localparam logic [ADDR_W-1:0] DBUF_LAST = 12'hFFF;
  localparam logic [7:0] DBUF_STORE_BASE = 8'h40;

  // ==========================================================
  // Register offsets
  localparam logic [ADDR_W-1:0] PORT_DATA_FIRST = 12'h000;
  localparam logic [ADDR_W-1:0] PORT_DATA_LAST = 12'h007;
  localparam logic [ADDR_W-1:0] PORT0_DIR = 12'h010;
  localparam logic [ADDR_W-1:0] PORT1_DIR = 12'h011;
  localparam logic [ADDR_W-1:0] PORT3_OUT_CTL = 12'h012;
  localparam logic [ADDR_W-1:0] PORT4_OUT_CTL = 12'h013;
  localparam logic [ADDR_W-1:0] PORT6_CTL_ONE = 12'h014;
  localparam logic [ADDR_W-1:0] PORT6_CTL_TWO = 12'h015;
  localparam logic [ADDR_W-1:0] PORT2_PIN_RD = 12'h016;
  localparam logic [ADDR_W-1:0] PORT3_PIN_RD = 12'h017;
  localparam logic [ADDR_W-1:0] TIMER3_CTL = 12'h018;
  localparam logic [ADDR_W-1:0] TIMER4_CTL = 12'h019;
  localparam logic [ADDR_W-1:0] TIMER3_PERIOD = 12'h01C;
  localparam logic [ADDR_W-1:0] TIMER4_PERIOD = 12'h01D;
  localparam logic [ADDR_W-1:0] CONV_RESULT_TWO = 12'h020;
  localparam logic [ADDR_W-1:0] CONV_RESULT_ONE = 12'h021;
  localparam logic [ADDR_W-1:0] PORT4_PIN_RD = 12'h022;
  localparam logic [ADDR_W-1:0] PORT5_PIN_RD = 12'h023;
  localparam logic [ADDR_W-1:0] PORT7_PIN_RD = 12'h024;
  localparam logic [ADDR_W-1:0] ASER_STAT_CTL_ONE = 12'h025;
  localparam logic [ADDR_W-1:0] ASER_CTL_TWO = 12'h026;
  localparam logic [ADDR_W-1:0] WDOG_CTL_ONE = 12'h034;
  localparam logic [ADDR_W-1:0] WDOG_CTL_TWO = 12'h035;
  localparam logic [ADDR_W-1:0] EXT_IRQ_CTL = 12'h037;
  localparam logic [ADDR_W-1:0] SYS_CTL_TWO = 12'h039;
  localparam logic [ADDR_W-1:0] IRQ_EN_LOW = 12'h03A;
  localparam logic [ADDR_W-1:0] IRQ_EN_HIGH = 12'h03B;
  localparam logic [ADDR_W-1:0] IRQ_LATCH_LOW = 12'h03C;
  localparam logic [ADDR_W-1:0] IRQ_LATCH_HIGH = 12'h03D;
  localparam logic [ADDR_W-1:0] STATUS_WORD = 12'h03F;
  localparam logic [ADDR_W-1:0] SSER_CTL_ONE = 12'hFA8;
  localparam logic [ADDR_W-1:0] SSER_STAT_CTL_TWO = 12'hFA9;
  localparam logic [ADDR_W-1:0] STOP_REL_CTL = 12'hFAA;
  localparam logic [ADDR_W-1:0] ASER_BUF = 12'hFAB;
  localparam logic [ADDR_W-1:0] PORT0_SEG = 12'hFAC;
  localparam logic [ADDR_W-1:0] PORT1_SEG = 12'hFAD;
  localparam logic [ADDR_W-1:0] PORT5_SEG = 12'hFAE;
  localparam logic [ADDR_W-1:0] PORT7_SEG = 12'hFAF;
  localparam logic [ADDR_W-1:0] CAP_A_LOW = 12'hFB4;
  localparam logic [ADDR_W-1:0] CAP_A_HIGH = 12'hFB5;
  localparam logic [ADDR_W-1:0] CAP_B_LOW = 12'hFB6;
  localparam logic [ADDR_W-1:0] CAP_B_HIGH = 12'hFB7;
  localparam logic [ADDR_W-1:0] PIN_FUNC_SEL = 12'hFBB;

  // Plain read/write ranges of peripherals kept as storage
  localparam logic [ADDR_W-1:0] GEN_A_FIRST = 12'h008;
  localparam logic [ADDR_W-1:0] GEN_A_LAST = 12'h00F;
  localparam logic [ADDR_W-1:0] GEN_B_FIRST = 12'h01A;
  localparam logic [ADDR_W-1:0] GEN_B_LAST = 12'h01B;
  localparam logic [ADDR_W-1:0] GEN_C_FIRST = 12'h028;
  localparam logic [ADDR_W-1:0] GEN_C_LAST = 12'h02E;
  localparam logic [ADDR_W-1:0] GEN_D = 12'h036;
  localparam logic [ADDR_W-1:0] GEN_E = 12'h038;
  localparam logic [ADDR_W-1:0] SEG_DATA_FIRST = 12'hF80;
  localparam logic [ADDR_W-1:0] SEG_DATA_LAST = 12'hF93;
  localparam logic [ADDR_W-1:0] SSER_BUF_FIRST = 12'hFA0;
  localparam logic [ADDR_W-1:0] SSER_BUF_LAST = 12'hFA7;
  localparam logic [ADDR_W-1:0] TMR7_DATA_FIRST = 12'hFB0;
  localparam logic [ADDR_W-1:0] TMR7_DATA_LAST = 12'hFB3;

  // ==========================================================
  // Reset value and external read source slots
  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
  localparam logic [3:0] EXT_CONV_TWO = 4'h0;
  localparam logic [3:0] EXT_CONV_ONE = 4'h1;
  localparam logic [3:0] EXT_ASER_STAT = 4'h2;
  localparam logic [3:0] EXT_SSER_STAT = 4'h3;
  localparam logic [3:0] EXT_ASER_RX = 4'h4;
  localparam logic [3:0] EXT_CAP_A_LOW = 4'h5;
  localparam logic [3:0] EXT_CAP_A_HIGH = 4'h6;
  localparam logic [3:0] EXT_CAP_B_LOW = 4'h7;
  localparam logic [3:0] EXT_CAP_B_HIGH = 4'h8;

  // ==========================================================
  // Types
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SUB1 = 4'b0010,
    ST_SUB2 = 4'b0100,
    ST_SUB3 = 4'b1000
  } prmpio_state_t;

  typedef enum logic [3:0] {
    ACC_RES = 4'h0,
    ACC_RW = 4'h1,
    ACC_WO = 4'h2,
    ACC_RO = 4'h3,
    ACC_MIX = 4'h4,
    ACC_PORT = 4'h5,
    ACC_DIR = 4'h6,
    ACC_SEG = 4'h7,
    ACC_PIN = 4'h8
  } prmpio_acc_t;

  typedef struct packed {
    prmpio_acc_t cls;
    logic [3:0] sel;
  } prmpio_dec_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } prmpio_req_t;

  typedef struct packed {
    logic valid;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } prmpio_wev_t;

  typedef logic [EXT_N-1:0][DATA_W-1:0] prmpio_ext_t;
  typedef logic [NPORT-1:0][DATA_W-1:0] prmpio_pins_t;

endpackage

// >>> prmpio_top.sv
`timescale 1ns/1ps
`default_nettype none

// What this block does
// RULE1 - Peripherals reached only by loads and stores
// RULE2 - Decode 0000H to 003FH as special-function region
// RULE3 - Decode 0F80H to 0FFFH as data-buffer region
// RULE4 - Software never touches reserved addresses
// RULE5 - Missing direction means no access that way
// RULE6 - No read-modify-write on write-only or latches
// RULE7 - Eight ports; third three bits, fifth four
// RULE8 - Output bits driven from held write latch
// RULE9 - Port inputs unlatched; read returns live pins
// RULE10 - Pins sampled in first bus substate
// RULE11 - Latch and pins update in second substate
// RULE12 - Software filters bouncing inputs itself
// RULE13 - Every register eight bits, one byte cycle
// RULE14 - Output-configured bit reads back latch contents
module prmpio_top (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Processor bus
  input wire prmpio_pkg::prmpio_req_t bus_req_i,
  output logic bus_busy_o,
  output logic bus_ack_o,
  output logic [prmpio_pkg::DATA_W-1:0] bus_rdata_o,
  // Port pins
  input wire prmpio_pkg::prmpio_pins_t pin_in_i,
  output prmpio_pkg::prmpio_pins_t pin_out_o,
  output prmpio_pkg::prmpio_pins_t pin_oe_o,
  // Peripheral side
  input wire prmpio_pkg::prmpio_ext_t periph_rd_i,
  output prmpio_pkg::prmpio_wev_t periph_wr_o
);

  // ==========================================================
  // Decode helpers

  // Classify one address into access kind and selector
  function automatic prmpio_pkg::prmpio_dec_t decode(input logic [prmpio_pkg::ADDR_W-1:0] a);
    prmpio_pkg::prmpio_dec_t d;
    d.cls = prmpio_pkg::ACC_RES;
    d.sel = 4'h0;
    // Reserved or outside both regions by default
    if (a >= prmpio_pkg::PORT_DATA_FIRST && a <= prmpio_pkg::PORT_DATA_LAST)
    begin
      d.cls = prmpio_pkg::ACC_PORT;
      d.sel = a[3:0];
    end
    else if ((a >= prmpio_pkg::GEN_A_FIRST && a <= prmpio_pkg::GEN_A_LAST) ||
             (a >= prmpio_pkg::GEN_B_FIRST && a <= prmpio_pkg::GEN_B_LAST) ||
             (a >= prmpio_pkg::GEN_C_FIRST && a <= prmpio_pkg::GEN_C_LAST) ||
             (a >= prmpio_pkg::SEG_DATA_FIRST && a <= prmpio_pkg::SEG_DATA_LAST) ||
             (a >= prmpio_pkg::SSER_BUF_FIRST && a <= prmpio_pkg::SSER_BUF_LAST) ||
             (a >= prmpio_pkg::TMR7_DATA_FIRST && a <= prmpio_pkg::TMR7_DATA_LAST))
    begin
      d.cls = prmpio_pkg::ACC_RW;
    end
    else
    begin
      case (a)
        // Direction style controls, selector is the port
        prmpio_pkg::PORT0_DIR: begin d.cls = prmpio_pkg::ACC_DIR; d.sel = 4'h0; end
        prmpio_pkg::PORT1_DIR: begin d.cls = prmpio_pkg::ACC_DIR; d.sel = 4'h1; end
        prmpio_pkg::PORT3_OUT_CTL: begin d.cls = prmpio_pkg::ACC_DIR; d.sel = 4'h3; end
        prmpio_pkg::PORT4_OUT_CTL: begin d.cls = prmpio_pkg::ACC_DIR; d.sel = 4'h4; end
        prmpio_pkg::PORT6_CTL_ONE: begin d.cls = prmpio_pkg::ACC_DIR; d.sel = 4'h6; end
        // Segment selects
        prmpio_pkg::PORT0_SEG: begin d.cls = prmpio_pkg::ACC_SEG; d.sel = 4'h0; end
        prmpio_pkg::PORT1_SEG: begin d.cls = prmpio_pkg::ACC_SEG; d.sel = 4'h1; end
        prmpio_pkg::PORT5_SEG: begin d.cls = prmpio_pkg::ACC_SEG; d.sel = 4'h5; end
        prmpio_pkg::PORT7_SEG: begin d.cls = prmpio_pkg::ACC_SEG; d.sel = 4'h7; end
        // Raw pin reads
        prmpio_pkg::PORT2_PIN_RD: begin d.cls = prmpio_pkg::ACC_PIN; d.sel = 4'h2; end
        prmpio_pkg::PORT3_PIN_RD: begin d.cls = prmpio_pkg::ACC_PIN; d.sel = 4'h3; end
        prmpio_pkg::PORT4_PIN_RD: begin d.cls = prmpio_pkg::ACC_PIN; d.sel = 4'h4; end
        prmpio_pkg::PORT5_PIN_RD: begin d.cls = prmpio_pkg::ACC_PIN; d.sel = 4'h5; end
        prmpio_pkg::PORT7_PIN_RD: begin d.cls = prmpio_pkg::ACC_PIN; d.sel = 4'h7; end
        // Read-only peripheral values
        prmpio_pkg::CONV_RESULT_TWO: begin d.cls = prmpio_pkg::ACC_RO; d.sel = prmpio_pkg::EXT_CONV_TWO; end
        prmpio_pkg::CONV_RESULT_ONE: begin d.cls = prmpio_pkg::ACC_RO; d.sel = prmpio_pkg::EXT_CONV_ONE; end
        prmpio_pkg::CAP_A_LOW: begin d.cls = prmpio_pkg::ACC_RO; d.sel = prmpio_pkg::EXT_CAP_A_LOW; end
        prmpio_pkg::CAP_A_HIGH: begin d.cls = prmpio_pkg::ACC_RO; d.sel = prmpio_pkg::EXT_CAP_A_HIGH; end
        prmpio_pkg::CAP_B_LOW: begin d.cls = prmpio_pkg::ACC_RO; d.sel = prmpio_pkg::EXT_CAP_B_LOW; end
        prmpio_pkg::CAP_B_HIGH: begin d.cls = prmpio_pkg::ACC_RO; d.sel = prmpio_pkg::EXT_CAP_B_HIGH; end
        // Read one register, write another
        prmpio_pkg::ASER_STAT_CTL_ONE: begin d.cls = prmpio_pkg::ACC_MIX; d.sel = prmpio_pkg::EXT_ASER_STAT; end
        prmpio_pkg::SSER_STAT_CTL_TWO: begin d.cls = prmpio_pkg::ACC_MIX; d.sel = prmpio_pkg::EXT_SSER_STAT; end
        prmpio_pkg::ASER_BUF: begin d.cls = prmpio_pkg::ACC_MIX; d.sel = prmpio_pkg::EXT_ASER_RX; end
        // Write-only controls
        prmpio_pkg::ASER_CTL_TWO,
        prmpio_pkg::WDOG_CTL_ONE,
        prmpio_pkg::WDOG_CTL_TWO,
        prmpio_pkg::SSER_CTL_ONE,
        prmpio_pkg::STOP_REL_CTL: d.cls = prmpio_pkg::ACC_WO;
        // Plain read/write controls
        prmpio_pkg::PORT6_CTL_TWO,
        prmpio_pkg::TIMER3_CTL,
        prmpio_pkg::TIMER4_CTL,
        prmpio_pkg::TIMER3_PERIOD,
        prmpio_pkg::TIMER4_PERIOD,
        prmpio_pkg::GEN_D,
        prmpio_pkg::EXT_IRQ_CTL,
        prmpio_pkg::GEN_E,
        prmpio_pkg::SYS_CTL_TWO,
        prmpio_pkg::IRQ_EN_LOW,
        prmpio_pkg::IRQ_EN_HIGH,
        prmpio_pkg::IRQ_LATCH_LOW,
        prmpio_pkg::IRQ_LATCH_HIGH,
        prmpio_pkg::STATUS_WORD,
        prmpio_pkg::PIN_FUNC_SEL: d.cls = prmpio_pkg::ACC_RW;
        default: d.cls = prmpio_pkg::ACC_RES;
      endcase
    end
    return d;
  endfunction

  // Storage slot: special-function region low 64, data-buffer region above
  function automatic logic [7:0] store_idx(input logic [prmpio_pkg::ADDR_W-1:0] a);
    logic [7:0] idx;
    idx = 8'h00;
    if (a <= prmpio_pkg::SPEC_LAST) // RULE2
    begin
      idx = {2'b00, a[5:0]};
    end
    else if (a >= prmpio_pkg::DBUF_FIRST) // RULE3
    begin
      idx = 8'(prmpio_pkg::DBUF_STORE_BASE + {1'b0, a[6:0]});
    end
    return idx;
  endfunction

  // ==========================================================
  // State and storage
  prmpio_pkg::prmpio_state_t state_ff; // Bus substate sequencer
  prmpio_pkg::prmpio_state_t nxt_state;
  prmpio_pkg::prmpio_req_t req_ff; // Held request of current cycle
  prmpio_pkg::prmpio_dec_t cur_dec; // Decode of held address
  logic [7:0] cur_idx; // Storage slot of held address
  logic [prmpio_pkg::DATA_W-1:0] mem_ff [prmpio_pkg::STORE_N]; // Plain registers
  prmpio_pkg::prmpio_pins_t latch_ff; // Output latches
  prmpio_pkg::prmpio_pins_t dir_ff; // Direction bits
  prmpio_pkg::prmpio_pins_t seg_ff; // Segment select bits
  prmpio_pkg::prmpio_pins_t oe_ff; // Pin drive enables
  prmpio_pkg::prmpio_pins_t nxt_latch;
  prmpio_pkg::prmpio_pins_t nxt_dir;
  prmpio_pkg::prmpio_pins_t nxt_seg;
  prmpio_pkg::prmpio_pins_t port_rd; // Per-port data read value
  logic [prmpio_pkg::DATA_W-1:0] nxt_rdata;
  logic [prmpio_pkg::DATA_W-1:0] rdata_ff; // Read answer
  logic ack_ff; // Answer strobe
  logic busy_ff; // Cycle in progress
  prmpio_pkg::prmpio_wev_t wev_ff; // Write notice to peripherals
  logic commit; // Write step of a write cycle
  logic writable; // Held address accepts writes

  assign cur_dec = decode(req_ff.addr);
  assign cur_idx = store_idx(req_ff.addr);
  assign commit = (state_ff == prmpio_pkg::ST_SUB2) && req_ff.wr; // RULE11
  // Read-only, pin-read and reserved addresses take no write
  assign writable = (cur_dec.cls != prmpio_pkg::ACC_RO) &&
                    (cur_dec.cls != prmpio_pkg::ACC_PIN) &&
                    (cur_dec.cls != prmpio_pkg::ACC_RES); // RULE5

  // ==========================================================
  // Bus substate sequencer

  // Idle, first, second, third substate, then idle
  always_comb
  begin
    case (state_ff)
      prmpio_pkg::ST_IDLE: nxt_state = (bus_req_i.rd || bus_req_i.wr) ? prmpio_pkg::ST_SUB1 : prmpio_pkg::ST_IDLE;
      prmpio_pkg::ST_SUB1: nxt_state = prmpio_pkg::ST_SUB2;
      prmpio_pkg::ST_SUB2: nxt_state = prmpio_pkg::ST_SUB3;
      prmpio_pkg::ST_SUB3: nxt_state = prmpio_pkg::ST_IDLE;
      default: nxt_state = prmpio_pkg::ST_IDLE;
    endcase
  end

  // Substate register
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
      state_ff <= prmpio_pkg::ST_IDLE;
    else
      state_ff <= nxt_state;
  end

  // Capture one byte request while idle
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
      req_ff <= '0;
    else if (state_ff == prmpio_pkg::ST_IDLE && (bus_req_i.rd || bus_req_i.wr)) // RULE1 RULE13
    begin
      req_ff <= bus_req_i;
      // A request with both strobes is a read
      if (bus_req_i.rd)
        req_ff.wr <= 1'b0;
    end
  end

  // Busy and answer strobe
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      busy_ff <= 1'b0;
      ack_ff <= 1'b0;
    end
    else
    begin
      busy_ff <= (nxt_state != prmpio_pkg::ST_IDLE);
      ack_ff <= (state_ff == prmpio_pkg::ST_SUB2);
    end
  end

  // ==========================================================
  // Port read paths
  generate
    for (genvar p = 0; p < prmpio_pkg::NPORT; p++)
    begin : g_port_rd
      // Output bits read latch, input bits read live pins, segment inputs read zero
      assign port_rd[p] = ((latch_ff[p] & dir_ff[p]) |
                          (pin_in_i[p] & ~dir_ff[p] & ~seg_ff[p])) & prmpio_pkg::PORT_MASK[p]; // RULE9 RULE14
    end
  endgenerate

  // Read data select by access kind
  always_comb
  begin
    nxt_rdata = prmpio_pkg::REG_RESET;
    case (cur_dec.cls)
      prmpio_pkg::ACC_PORT: nxt_rdata = port_rd[cur_dec.sel[2:0]];
      prmpio_pkg::ACC_PIN: nxt_rdata = pin_in_i[cur_dec.sel[2:0]] & prmpio_pkg::PORT_MASK[cur_dec.sel[2:0]]; // RULE9
      prmpio_pkg::ACC_DIR: nxt_rdata = dir_ff[cur_dec.sel[2:0]];
      prmpio_pkg::ACC_SEG: nxt_rdata = seg_ff[cur_dec.sel[2:0]];
      prmpio_pkg::ACC_RO,
      prmpio_pkg::ACC_MIX: nxt_rdata = periph_rd_i[cur_dec.sel];
      prmpio_pkg::ACC_RW: nxt_rdata = mem_ff[cur_idx];
      prmpio_pkg::ACC_WO: nxt_rdata = prmpio_pkg::REG_RESET; // RULE5
      default: nxt_rdata = prmpio_pkg::REG_RESET;
    endcase
  end

  // Sample read data in the first substate
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
      rdata_ff <= prmpio_pkg::REG_RESET;
    else if (state_ff == prmpio_pkg::ST_SUB1 && req_ff.rd) // RULE10
      rdata_ff <= nxt_rdata;
  end

  // ==========================================================
  // Port write paths

  // Next latch, direction and segment values
  always_comb
  begin
    nxt_latch = latch_ff;
    nxt_dir = dir_ff;
    nxt_seg = seg_ff;
    if (commit)
    begin
      case (cur_dec.cls)
        prmpio_pkg::ACC_PORT: nxt_latch[cur_dec.sel[2:0]] = req_ff.wdata & prmpio_pkg::PORT_MASK[cur_dec.sel[2:0]]; // RULE8 RULE7
        prmpio_pkg::ACC_DIR: nxt_dir[cur_dec.sel[2:0]] = req_ff.wdata & prmpio_pkg::PORT_MASK[cur_dec.sel[2:0]];
        prmpio_pkg::ACC_SEG: nxt_seg[cur_dec.sel[2:0]] = req_ff.wdata;
        default: nxt_latch = latch_ff;
      endcase
    end
    // Ports without a direction register are always latch-read
    nxt_dir[2] = prmpio_pkg::PORT_MASK[2];
    nxt_dir[5] = prmpio_pkg::PORT_MASK[5];
    nxt_dir[7] = prmpio_pkg::PORT_MASK[7];
  end

  // Latch, direction, segment and drive enable registers
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      latch_ff <= '0;
      dir_ff <= '0;
      seg_ff <= '0;
      oe_ff <= '0;
    end
    else
    begin
      latch_ff <= nxt_latch; // RULE11
      dir_ff <= nxt_dir;
      seg_ff <= nxt_seg;
      for (int p = 0; p < prmpio_pkg::NPORT; p++)
      begin
        // Direction ports drive outputs; the rest pull low only on zero
        if (p == 2 || p == 5 || p == 7)
          oe_ff[p] <= ~nxt_latch[p] & ~nxt_seg[p] & prmpio_pkg::PORT_MASK[p];
        else
          oe_ff[p] <= nxt_dir[p] & ~nxt_seg[p]; // RULE8
      end
    end
  end

  // ==========================================================
  // Plain register storage

  // Plain, write-only and write half of paired registers
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      for (int i = 0; i < prmpio_pkg::STORE_N; i++)
        mem_ff[i] <= prmpio_pkg::REG_RESET;
    end
    else if (commit && (cur_dec.cls == prmpio_pkg::ACC_RW ||
                        cur_dec.cls == prmpio_pkg::ACC_WO ||
                        cur_dec.cls == prmpio_pkg::ACC_MIX)) // RULE5
    begin
      mem_ff[cur_idx] <= req_ff.wdata;
    end
  end

  // Write notice, one cycle, after each accepted write
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
      wev_ff <= '0;
    else
    begin
      wev_ff.valid <= commit && writable;
      wev_ff.addr <= req_ff.addr;
      wev_ff.data <= req_ff.wdata;
    end
  end

  // ==========================================================
  // Outputs
  assign bus_busy_o = busy_ff;
  assign bus_ack_o = ack_ff;
  assign bus_rdata_o = rdata_ff;
  assign pin_out_o = latch_ff;
  assign pin_oe_o = oe_ff;
  assign periph_wr_o = wev_ff;

endmodule

`default_nettype wire

// >>> testbench.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Register map and port pin tests
module testbench;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  prmpio_pkg::prmpio_req_t req;
  logic busy, ack;
  logic [7:0] rdata;
  prmpio_pkg::prmpio_pins_t pin_in = '0;
  prmpio_pkg::prmpio_pins_t pin_out, pin_oe;
  prmpio_pkg::prmpio_ext_t ext = '0;
  prmpio_pkg::prmpio_wev_t wev;
  int error_cnt = 0;
  int num_checks = 0;
  // Store, then load, expected load, expected event (2 = plain storage, event too)
  localparam logic [11:0] TA [12] = '{12'h03F, 12'hF80, 12'hFBB, 12'h026, 12'hFAA, 12'h020,
    12'hFB7, 12'h025, 12'hFAB, 12'h800, 12'h040, 12'hF7F};
  localparam logic [7:0] TE [12] = '{8'hA5, 8'h5A, 8'hC3, 8'h00, 8'h00, 8'h3C,
    8'hE1, 8'h5D, 8'h4B, 8'h00, 8'h00, 8'h00};
  localparam logic [1:0] TV [12] = '{2'h2, 2'h2, 2'h2, 2'h1, 2'h1, 2'h0, 2'h0, 2'h1, 2'h1, 2'h0, 2'h0, 2'h0};
  initial forever #5 mclk_i = ~mclk_i;
  prmpio_top u_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .bus_req_i(req), .bus_busy_o(busy),
    .bus_ack_o(ack), .bus_rdata_o(rdata), .pin_in_i(pin_in), .pin_out_o(pin_out), .pin_oe_o(pin_oe),
    .periph_rd_i(ext), .periph_wr_o(wev));
  prmpio_core_model u_core (.mclk_i(mclk_i), .bus_ack_o(ack), .bus_rdata_o(rdata), .bus_req_o(req));
  // Byte compare
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [7:0] q;
    u_core.xfer(1'b0, a, d, q);
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
    logic [7:0] q;
    u_core.xfer(1'b1, a, 8'h00, q);
    chk8(q, exp);
  endtask
  task automatic tally_and_finish;
    error_cnt += u_core.hang_cnt;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Hang guard
  initial
  begin
    repeat (5000) @(posedge mclk_i);
    error_cnt++;
    tally_and_finish();
  end
  // Main sequence
  initial
  begin
    repeat (3) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    ext[0] <= 8'h3C;
    ext[2] <= 8'h5D;
    ext[4] <= 8'h4B;
    ext[8] <= 8'hE1;
    pin_in[0] <= 8'h96;
    rd_chk(12'h010, 8'h00);
    rd_chk(12'h000, 8'h96);
    // Port 0 upper nibble output
    wr(12'h010, 8'hF0);
    wr(12'h000, 8'h5A);
    chk8(pin_out[0], 8'h5A);
    chk8(pin_oe[0], 8'hF0);
    pin_in[0] <= 8'h33;
    rd_chk(12'h000, 8'h53);
    pin_in[0] <= 8'hFF;
    wr(12'hFAC, 8'h3C);
    chk8(pin_oe[0], 8'hC0);
    rd_chk(12'h000, 8'h53);
    // Sample moment of an input read
    pin_in[1] <= 8'h11;
    fork
      rd_chk(12'h001, 8'h22);
      begin
        repeat (2) @(posedge mclk_i);
        pin_in[1] <= 8'h22;
        @(posedge mclk_i);
        pin_in[1] <= 8'h44;
      end
    join
    // Raw pin read of the three bit port and segment select readback
    pin_in[2] <= 8'hFD;
    rd_chk(12'h016, 8'h05);
    rd_chk(12'hFAC, 8'h3C);
    // Access kinds across both regions
    for (int i = 0; i < 12; i++)
    begin
      wr(TA[i], TE[i] ^ 8'hFF ^ {7'h00, TV[i] == 2'h2});
      chk8({7'h00, wev.valid}, {7'h00, TV[i] != 2'h0});
      rd_chk(TA[i], (TV[i] == 2'h2) ? TE[i] ^ 8'hFE : TE[i]);
    end
    // Four bit port and held latch
    wr(12'h013, 8'hFF);
    chk8(pin_oe[4], 8'h0F);
    chk8(pin_out[0], 8'h5A);
    tally_and_finish();
  end
endmodule
`default_nettype wire
